// file: verilog/ussc_top.sv
// Serial status flags, error detection, sample control and register access
`timescale 1ns/100ps
module ussc_top #(
  parameter int STEP_CYCLES = ussc_pkg::STEP_CYCLES,
  parameter int DATA_BITS   = ussc_pkg::DATA_BITS
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       ale_i,
  input  wire logic       cs_n_i,
  input  wire logic       rd_n_i,
  input  wire logic       wr_n_i,
  input  wire logic [7:0] ad_i,
  output logic      [7:0] ad_o,
  output logic            ad_oe_n_o,
  input  wire logic       irq_ack_n_i,
  output logic            irq_o,
  input  wire logic       serial_rx_in_i,
  input  wire logic       ext_rx_clock_i,
  input  wire logic       ext_clk_mode_i,
  input  wire logic       cts_n_i,
  input  wire logic       break_in_n_i,
  output logic            serial_tx_o
);
  ussc_pkg::ussc_pins_s pins, meta, s, q;
  logic [3:0]  addr;
  logic        sel;
  logic [7:0]  wr_data;
  logic        rd_active, rd_done, wr_done, ack_done, rxc_rise;
  logic [7:0]  cmd1, cmd2, cmd3, modify;
  logic [1:0]  int_en, req;
  logic        soft_rst, status_rd, iar_rd, buf_rd;
  logic        fe, oe, pe, bd, tx_shift_empty, tx_holding_empty, rx_holding_full;
  logic [7:0]  status_vec, iar_vec;
  ussc_pkg::ussc_rx_e rx_st;
  ussc_pkg::ussc_tx_e tx_st;
  logic [DATA_BITS-1:0] rx_sh, rx_buf, tx_sh, tx_buf, tx_buf_q;
  logic [2:0]  rx_cnt, tx_cnt;
  logic        rx_par, stop_low, tx_seen, rx_samp, rx_end, tx_end;
  logic        stop_samp, brk, perr, rx_fall;
  logic        tx_load, tx_done, brk_in_seen, brk_in_evt, next_tx;

  // Every pin except reset_n_i and ext_clk_mode_i passes two flops before any logic looks at it
  assign pins = '{ale_i, cs_n_i, rd_n_i, wr_n_i, cts_n_i, break_in_n_i, irq_ack_n_i,
                  serial_rx_in_i, ext_rx_clock_i, ad_i};

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= ussc_pkg::PINS_IDLE;
      s    <= ussc_pkg::PINS_IDLE;
      q    <= ussc_pkg::PINS_IDLE;
    end else begin
      meta <= pins;
      s    <= meta;
      q    <= s;
    end
  end

  assign rd_active = sel & ~s.rd_n;
  assign rd_done   = sel & s.rd_n & ~q.rd_n;
  assign wr_done   = sel & s.wr_n & ~q.wr_n;
  assign ack_done  = s.ack_n & ~q.ack_n;
  assign rxc_rise  = s.ext_rx_clock & ~q.ext_rx_clock;
  assign status_rd = rd_done & (addr == ussc_pkg::ADDR_STATUS);
  assign iar_rd    = rd_done & (addr == ussc_pkg::ADDR_INT_ADDR);
  assign buf_rd    = rd_done & (addr == ussc_pkg::ADDR_BUF);
  assign soft_rst  = wr_done & (addr == ussc_pkg::ADDR_CMD3) & wr_data[ussc_pkg::CMD3_SOFT_RST];

  // Address and chip select are caught as the latch enable falls
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr    <= 4'h0;
      sel     <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      if (q.ale && !s.ale) begin
        addr <= s.ad[3:0];
        sel  <= ~s.cs_n;
      end
      if (sel && !s.wr_n) begin
        wr_data <= s.ad;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd1   <= ussc_pkg::CMD_RESET;
      cmd2   <= ussc_pkg::CMD_RESET;
      cmd3   <= ussc_pkg::CMD_RESET;
      modify <= ussc_pkg::MOD_RESET;
      int_en <= ussc_pkg::INT_RESET;
    end else if (wr_done) begin
      case (addr)
        ussc_pkg::ADDR_CMD1:    cmd1 <= wr_data;
        ussc_pkg::ADDR_CMD2:    cmd2 <= wr_data;
        ussc_pkg::ADDR_CMD3: begin
          cmd3 <= wr_data;
          cmd3[ussc_pkg::CMD3_SOFT_RST] <= 1'b0;
        end
        ussc_pkg::ADDR_INT_SET: int_en <= int_en | wr_data[ussc_pkg::LVL_TX:ussc_pkg::LVL_RX];
        ussc_pkg::ADDR_INT_RST: int_en <= int_en & ~wr_data[ussc_pkg::LVL_TX:ussc_pkg::LVL_RX];
        ussc_pkg::ADDR_MODIFY:  modify <= wr_data;
        default: ;
      endcase
    end
  end

  assign status_vec = {irq_o, rx_holding_full, tx_holding_empty, tx_shift_empty, bd, pe, oe, fe};
  assign iar_vec    = (req[0] & int_en[0]) ? ussc_pkg::VEC_RX
                    : ((req[1] & int_en[1]) ? ussc_pkg::VEC_TX : 8'h00);

  // Read data is held in a register; the bus is driven only while read is low
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ad_o      <= 8'h00;
      ad_oe_n_o <= 1'b1;
    end else begin
      ad_oe_n_o <= ~rd_active;
      if (rd_active) begin
        case (addr)
          ussc_pkg::ADDR_CMD1:     ad_o <= cmd1;
          ussc_pkg::ADDR_CMD2:     ad_o <= cmd2;
          ussc_pkg::ADDR_CMD3:     ad_o <= cmd3;
          ussc_pkg::ADDR_INT_SET:  ad_o <= {2'b00, int_en, 4'h0};
          ussc_pkg::ADDR_INT_ADDR: ad_o <= iar_vec;
          ussc_pkg::ADDR_BUF:      ad_o <= 8'(rx_buf);
          ussc_pkg::ADDR_STATUS:   ad_o <= status_vec;
          default:                 ad_o <= 8'h00;
        endcase
      end
    end
  end

  // Receiver
  ussc_bit_timer #(.STEP_CYCLES(STEP_CYCLES)) u_rx_timer (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .run_i       (rx_st != ussc_pkg::RX_IDLE),
    .ext_mode_i  (ext_clk_mode_i),
    .ext_edge_i  (rxc_rise),
    .sample_pt_i (ussc_pkg::ussc_sample_point(modify[ussc_pkg::MOD_RS_MSB:ussc_pkg::MOD_RS_LSB])),
    .sample_o    (rx_samp),
    .bit_end_o   (rx_end)
  );

  assign rx_fall   = q.rxd & ~s.rxd & cmd3[ussc_pkg::CMD3_RX_EN];
  assign stop_samp = (rx_st == ussc_pkg::RX_STOP) & rx_samp;
  assign brk       = (rx_sh == '0) & ~s.rxd
                   & (~cmd2[ussc_pkg::CMD2_PARITY_EN] | ~rx_par);
  assign perr      = cmd2[ussc_pkg::CMD2_PARITY_EN]
                   & ((^{rx_sh, rx_par}) ^ ~cmd2[ussc_pkg::CMD2_EVEN_SEL]);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_st    <= ussc_pkg::RX_IDLE;
      rx_cnt   <= 3'h0;
      rx_sh    <= '0;
      rx_par   <= 1'b0;
      stop_low <= 1'b0;
    end else begin
      case (rx_st)
        ussc_pkg::RX_IDLE: begin
          if (rx_fall) begin
            rx_st <= ussc_pkg::RX_START;
          end
        end
        ussc_pkg::RX_START: begin
          if (rx_samp && s.rxd && !modify[ussc_pkg::MOD_DSC]) begin
            rx_st <= ussc_pkg::RX_IDLE;
          end else if (rx_end) begin
            rx_st  <= ussc_pkg::RX_DATA;
            rx_cnt <= 3'h0;
          end
        end
        ussc_pkg::RX_DATA: begin
          if (rx_samp) begin
            rx_sh <= {s.rxd, rx_sh[DATA_BITS-1:1]};
          end
          if (rx_end) begin
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == 3'(DATA_BITS - 1)) begin
              rx_st <= cmd2[ussc_pkg::CMD2_PARITY_EN] ? ussc_pkg::RX_PARITY : ussc_pkg::RX_STOP;
            end
          end
        end
        ussc_pkg::RX_PARITY: begin
          if (rx_samp) begin
            rx_par <= s.rxd;
          end
          if (rx_end) begin
            rx_st <= ussc_pkg::RX_STOP;
          end
        end
        ussc_pkg::RX_STOP: begin
          if (stop_samp && brk) begin
            rx_st <= ussc_pkg::RX_IDLE;
          end else begin
            if (rx_samp) begin
              stop_low <= ~s.rxd;
            end
            if (rx_end) begin
              // A low stop bit already counts as the next start bit
              rx_st  <= (rx_samp ? ~s.rxd : stop_low) ? ussc_pkg::RX_DATA : ussc_pkg::RX_IDLE;
              rx_cnt <= 3'h0;
              rx_par <= 1'b0;
            end
          end
        end
        default: rx_st <= ussc_pkg::RX_IDLE;
      endcase
    end
  end

  // Echo mode: remember whether our own transmitter ran during this frame
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_seen <= 1'b0;
    end else if (rx_st == ussc_pkg::RX_IDLE || (rx_st == ussc_pkg::RX_STOP && rx_end)) begin
      tx_seen <= 1'b0;
    end else if (tx_st != ussc_pkg::TX_IDLE) begin
      tx_seen <= 1'b1;
    end
  end

  // Buffer contents survive reset, so no reset branch here
  always_ff @(posedge clk_sys_i) begin
    if (stop_samp && !brk) begin
      rx_buf <= rx_sh;
    end
  end

  // Receive flags: clears come first so a coinciding set wins
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fe  <= 1'b0;
      oe  <= 1'b0;
      pe  <= 1'b0;
      bd  <= 1'b0;
      rx_holding_full <= 1'b0;
    end else begin
      if (status_rd && !modify[ussc_pkg::MOD_TME]) fe <= 1'b0;
      if (status_rd || soft_rst) oe <= 1'b0;
      if (status_rd) pe <= 1'b0;
      if (status_rd || soft_rst) bd <= 1'b0;
      if (buf_rd) rx_holding_full <= 1'b0;
      if (stop_samp && !brk) begin
        if (modify[ussc_pkg::MOD_TME]) begin
          fe <= tx_seen;
        end else if (!s.rxd) begin
          fe <= 1'b1;
        end
        if (rx_holding_full) oe <= 1'b1;
        if (perr) pe <= 1'b1;
        rx_holding_full <= 1'b1;
      end
      if ((stop_samp && brk) || brk_in_evt) bd <= 1'b1;
    end
  end

  // Transmitter
  ussc_bit_timer #(.STEP_CYCLES(STEP_CYCLES)) u_tx_timer (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .run_i       (tx_st != ussc_pkg::TX_IDLE),
    .ext_mode_i  (1'b0),
    .ext_edge_i  (1'b0),
    .sample_pt_i (ussc_pkg::SP_CENTER),
    .sample_o    (),
    .bit_end_o   (tx_end)
  );

  assign tx_load = (tx_st == ussc_pkg::TX_IDLE) & ~tx_holding_empty & ~s.cts_n;
  assign tx_done = (tx_st == ussc_pkg::TX_STOP) & tx_end;

  always_ff @(posedge clk_sys_i) begin
    if (wr_done && addr == ussc_pkg::ADDR_BUF) begin
      tx_buf <= wr_data[DATA_BITS-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_st       <= ussc_pkg::TX_IDLE;
      tx_cnt      <= 3'h0;
      tx_sh       <= '0;
      tx_shift_empty         <= 1'b1;
      tx_holding_empty         <= 1'b1;
      brk_in_seen <= 1'b0;
      brk_in_evt  <= 1'b0;
    end else begin
      brk_in_evt <= 1'b0;
      case (tx_st)
        ussc_pkg::TX_IDLE: begin
          if (tx_load) begin
            tx_sh <= tx_buf;
            tx_shift_empty   <= 1'b0;
            tx_holding_empty   <= 1'b1;
            tx_st <= ussc_pkg::TX_START;
          end
        end
        ussc_pkg::TX_START: begin
          if (tx_end) begin
            tx_st  <= ussc_pkg::TX_DATA;
            tx_cnt <= 3'h0;
          end
        end
        ussc_pkg::TX_DATA: begin
          if (tx_end) begin
            tx_sh  <= tx_sh >> 1;
            tx_cnt <= tx_cnt + 3'h1;
            if (tx_cnt == 3'(DATA_BITS - 1)) begin
              tx_st <= cmd2[ussc_pkg::CMD2_PARITY_EN] ? ussc_pkg::TX_PARITY : ussc_pkg::TX_STOP;
            end
          end
        end
        ussc_pkg::TX_PARITY: begin
          if (tx_end) tx_st <= ussc_pkg::TX_STOP;
        end
        ussc_pkg::TX_STOP: begin
          if (cmd1[ussc_pkg::CMD1_BREAK_IN_EN] && !s.brk_in_n) brk_in_seen <= 1'b1;
          if (tx_end) begin
            tx_shift_empty         <= 1'b1;
            brk_in_evt  <= brk_in_seen | (cmd1[ussc_pkg::CMD1_BREAK_IN_EN] & ~s.brk_in_n);
            brk_in_seen <= 1'b0;
            tx_st       <= ussc_pkg::TX_IDLE;
          end
        end
        default: tx_st <= ussc_pkg::TX_IDLE;
      endcase
      if (wr_done && addr == ussc_pkg::ADDR_BUF) tx_holding_empty <= 1'b0;
    end
  end

  // Parity bit is sent from the original character, shifted out already
  always_comb begin
    case (tx_st)
      ussc_pkg::TX_START:  next_tx = 1'b0;
      ussc_pkg::TX_DATA:   next_tx = tx_sh[0];
      ussc_pkg::TX_PARITY: next_tx = (^tx_buf_q) ^ ~cmd2[ussc_pkg::CMD2_EVEN_SEL];
      default:             next_tx = 1'b1;
    endcase
  end

  // Copy of the character on the line, so a new buffer write cannot upset its parity
  always_ff @(posedge clk_sys_i) begin
    if (tx_load) tx_buf_q <= tx_buf;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) serial_tx_o <= 1'b1;
    else            serial_tx_o <= next_tx;
  end

  // Interrupt requests: bit 0 is the receive level, bit 1 the transmit level
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req   <= 2'b00;
      irq_o <= 1'b0;
    end else begin
      if (ack_done || iar_rd) begin
        if (req[0] && int_en[0]) req[0] <= 1'b0;
        else                     req[1] <= 1'b0;
      end
      if (stop_samp) req[0] <= 1'b1;
      if (tx_load || (tx_done && tx_holding_empty) || brk_in_evt) req[1] <= 1'b1;
      irq_o <= |(req & int_en);
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  tbe_write_clr_a: assert property (wr_done && addr == ussc_pkg::ADDR_BUF |=> !tx_holding_empty)
    else $error("holding empty not cleared by write");
  idle_load_a: assert property (tx_load |=> !tx_shift_empty && tx_holding_empty && tx_st == ussc_pkg::TX_START)
    else $error("idle transmitter did not load");
  cts_hold_a: assert property (tx_st == ussc_pkg::TX_IDLE && s.cts_n |=>
    tx_st == ussc_pkg::TX_IDLE && $stable(tx_shift_empty)) else $error("transmitter moved with cts high");
  rbf_load_a: assert property (stop_samp && !brk |=> rx_holding_full && rx_buf == $past(rx_sh))
    else $error("receive buffer not loaded");
  break_skip_a: assert property (stop_samp && brk |=>
    bd && $stable(rx_buf) && rx_st == ussc_pkg::RX_IDLE) else $error("break handled wrongly");
  status_alias_a: assert property (rd_active && addr == ussc_pkg::ADDR_STATUS |=>
    ad_o == $past(status_vec) && !ad_oe_n_o) else $error("status not read at shared address");
  echo_fe_hold_a: assert property (modify[ussc_pkg::MOD_TME] && status_rd && !stop_samp |=>
    fe == $past(fe)) else $error("echo framing bit cleared by read");
  rx_irq_path_a: assert property (stop_samp && int_en[0] && !ack_done && !iar_rd |->
    ##2 irq_o) else $error("receive event raised no interrupt");
  start_check_a: assert property (rx_st == ussc_pkg::RX_START && rx_samp && s.rxd &&
    !modify[ussc_pkg::MOD_DSC] |=> rx_st == ussc_pkg::RX_IDLE) else $error("start check failed");
  bd_read_clr_a: assert property (status_rd && !stop_samp && !brk_in_evt |=> !bd)
    else $error("break flag survived status read");

  break_rx_c: cover property (stop_samp && brk);
  char_rx_c:  cover property (stop_samp && !brk && perr);
  tx_load_c:  cover property (tx_load ##[1:1000] tx_done);
  brk_in_c:   cover property (brk_in_evt);
endmodule : ussc_top

// file: verilog/ussc_pkg.sv
// Shared constants, types and decode helpers of the serial status and sample-control block
// Notes on behaviour
// - With parity enabled, check received parity against selected polarity at first stop bit.
// - Received break sets break flag, requests level 4, skips buffer, waits next fall.
// - Enabled break-in during last stop bit sets break flag and requests level 5.
// - Break flag clears on status read, hardware reset or software reset.
// - Shift-empty sets on reset and after last stop bit, clears on load.
// - Clear-to-send high holds the transmitter idle and shift-empty set.
// - Idle transmitter moves a written character on at once; holding-empty sets again.
// - Holding-empty sets on reset or transfer, clears on buffer write, requests level 5.
// - Receive-full sets on buffer load at stop sample, clears on buffer read or reset.
// - Interrupt-pending bit mirrors the request pin; acknowledge or address read clears it.
// - Receiver error and full events request level 4 at first stop bit sample.
// - Shift-empty requests level 5 only with holding-empty set; break-in rides along.
// - Start check disabled keeps the receiver going when start sample is high.
// - Echo mode disables framing detection and gives bit 0 its echo meaning.
// - Sample point setting applies only with the internal receive clock.
// - Sample point is 16 or 32 minus low four bits, in 1/32 bit steps.
// - Modification register is write-only; its address reads the status register.
// - Hardware reset zeroes the modification register; software reset leaves it alone.
// - Hardware reset clears the command registers.
// - Hardware reset clears status except shift-empty and holding-empty, which set.
// - Hardware reset clears interrupt state, drives line marking, disables the receiver.
// - Hardware reset leaves receive and transmit buffer contents alone.
// - Echo mode sets framing bit if own transmitter ran; status read keeps it.
// - Normal mode flags framing at stop bit, still loads, low stop starts next.
package ussc_pkg;
  localparam logic [3:0] ADDR_CMD1     = 4'h0;
  localparam logic [3:0] ADDR_CMD2     = 4'h1;
  localparam logic [3:0] ADDR_CMD3     = 4'h2;
  localparam logic [3:0] ADDR_INT_SET  = 4'h5;
  localparam logic [3:0] ADDR_INT_RST  = 4'h6;
  localparam logic [3:0] ADDR_INT_ADDR = 4'h6;
  localparam logic [3:0] ADDR_BUF      = 4'h7;
  localparam logic [3:0] ADDR_STATUS   = 4'hF;
  localparam logic [3:0] ADDR_MODIFY   = 4'hF;

  localparam int CMD1_BREAK_IN_EN = 3;
  localparam int CMD2_PARITY_EN   = 7;
  localparam int CMD2_EVEN_SEL    = 6;
  localparam int CMD3_RX_EN       = 6;
  localparam int CMD3_SOFT_RST    = 7;

  localparam int ST_FE  = 0;
  localparam int ST_OE  = 1;
  localparam int ST_PE  = 2;
  localparam int ST_BD  = 3;
  localparam int ST_TRE = 4;
  localparam int ST_TBE = 5;
  localparam int ST_RBF = 6;
  localparam int ST_INT = 7;

  localparam int MOD_DSC    = 0;
  localparam int MOD_TME    = 1;
  localparam int MOD_RS_LSB = 2;
  localparam int MOD_RS_MSB = 6;

  localparam int LVL_RX = 4;
  localparam int LVL_TX = 5;
  localparam logic [7:0] VEC_RX = 8'(LVL_RX * 4);
  localparam logic [7:0] VEC_TX = 8'(LVL_TX * 4);

  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] MOD_RESET = 8'h00;
  localparam logic [1:0] INT_RESET = 2'h0;

  localparam int STEPS_PER_BIT       = 32;
  localparam logic [4:0] LAST_PHASE  = 5'(STEPS_PER_BIT - 1);
  localparam logic [5:0] SP_CENTER   = 6'h10;
  localparam logic [5:0] SP_END      = 6'h20;
  localparam int CLK_PERIOD_NS       = 100;
  localparam int STEP_TIME_NS        = 3200;
  localparam int STEP_CYCLES         = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_BITS           = 8;

  typedef struct packed {
    logic       ale;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       cts_n;
    logic       brk_in_n;
    logic       ack_n;
    logic       rxd;
    logic       ext_rx_clock;
    logic [7:0] ad;
  } ussc_pins_s;

  localparam ussc_pins_s PINS_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
                                       8'h00};

  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ussc_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ussc_tx_e;

  // Step of the bit in which the receiver samples, 1 to 32
  function automatic logic [5:0] ussc_sample_point(input logic [4:0] sel);
    ussc_sample_point = (sel[4] ? SP_END : SP_CENTER) - {2'b00, sel[3:0]};
  endfunction : ussc_sample_point
endpackage : ussc_pkg

// file: verilog/ussc_bit_timer.sv
// Bit timer: 1/32 bit steps, sample strobe at a chosen step, end-of-bit strobe
`timescale 1ns/100ps
module ussc_bit_timer #(
  parameter int STEP_CYCLES = ussc_pkg::STEP_CYCLES
) (
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       run_i,
  input  wire logic       ext_mode_i,
  input  wire logic       ext_edge_i,
  input  wire logic [5:0] sample_pt_i,
  output logic            sample_o,
  output logic            bit_end_o
);
  localparam int DW = $clog2(STEP_CYCLES + 1);

  logic [DW-1:0] div;
  logic [4:0]    phase;
  logic          step;

  assign step = (div == DW'(STEP_CYCLES - 1));

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div   <= '0;
      phase <= '0;
    end else if (!run_i || ext_mode_i) begin
      div   <= '0;
      phase <= '0;
    end else if (step) begin
      div   <= '0;
      phase <= phase + 5'h01;
    end else begin
      div <= div + DW'(1);
    end
  end

  // An external 1x clock gives one edge per bit, so sampling cannot be moved
  assign sample_o  = run_i & (ext_mode_i ? ext_edge_i
                     : (step & ({1'b0, phase} == sample_pt_i - 6'h01)));
  assign bit_end_o = run_i & (ext_mode_i ? ext_edge_i
                     : (step & (phase == ussc_pkg::LAST_PHASE)));

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sample_step_a: assert property (sample_o && !ext_mode_i |->
    ({1'b0, phase} + 6'h01 == sample_pt_i) && step) else $error("sample off its step");
endmodule : ussc_bit_timer

// file: test/ussc_remote_dev.sv
// Remote serial device model driving the receive line of the block
`timescale 1ns/100ps
module ussc_remote_dev #(
  parameter int BIT_CYCLES = 64
) (
  input  wire logic clk_sys_i,
  output logic      line_o
);
  initial line_o = 1'h1;

  // Start, 8 data LSB first, optional parity, one stop bit of the given level
  task automatic send(input logic [7:0] d, input logic par_en, input logic par,
                      input logic stop);
    logic b;
    for (int i = 0; i < 11; i++) begin
      b = (i == 0) ? 1'h0 : (i < 9) ? d[i - 1] : (i == 9) ? par : stop;
      if (i != 9 || par_en) begin
        @(negedge clk_sys_i);
        line_o = b;
        repeat (BIT_CYCLES - 1) @(negedge clk_sys_i);
      end
    end
    // Line marks again, so a break ends with a fresh falling edge later
    @(negedge clk_sys_i);
    line_o = 1'h1;
  endtask : send
endmodule : ussc_remote_dev

// file: test/tb_uart_status_and_sample_control.sv
// Self-checking bench for the serial status and sample-control block
`timescale 1ns/100ps
module tb_uart_status_and_sample_control;
  // Short bit time keeps each frame near 700 clocks
  localparam int STEPS = 2;
  typedef struct packed {logic wr; logic [3:0] a; logic [7:0] d;} ussc_row_s;
  logic       clk_sys = 1'h0;
  logic       reset_n = 1'h0;
  logic       ale = 1'h0;
  logic       cs_n = 1'h1;
  logic       rd_n = 1'h1;
  logic       wr_n = 1'h1;
  logic       ack_n = 1'h1;
  logic       cts_n = 1'h0;
  logic       brk_in_n = 1'h1;
  logic [7:0] ad = 8'h00;
  logic [7:0] ad_o;
  logic [7:0] rdat;
  logic       ad_oe_n;
  logic       irq;
  logic       rx;
  logic       tx;
  int         mismatches = 0;
  int         compares = 0;
  // Write rows carry data, read rows the expected value
  ussc_row_s  rows [8] = '{'{1'h0, 4'hF, 8'h30}, '{1'h1, 4'h0, 8'h08}, '{1'h0, 4'h0, 8'h08},
                           '{1'h1, 4'hF, 8'h00}, '{1'h0, 4'hF, 8'h30}, '{1'h0, 4'h3, 8'h00},
                           '{1'h1, 4'h5, 8'h30}, '{1'h0, 4'h5, 8'h30}};

  always #50 clk_sys = ~clk_sys;

  ussc_top #(.STEP_CYCLES(STEPS)) u_ussc_top (
    .clk_sys_i(clk_sys), .reset_n_i(reset_n), .ale_i(ale), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .ad_i(ad), .ad_o(ad_o), .ad_oe_n_o(ad_oe_n), .irq_ack_n_i(ack_n),
    .irq_o(irq), .serial_rx_in_i(rx), .ext_rx_clock_i(1'h0), .ext_clk_mode_i(1'h0),
    .cts_n_i(cts_n), .break_in_n_i(brk_in_n), .serial_tx_o(tx));

  ussc_remote_dev #(.BIT_CYCLES(32 * STEPS)) u_ussc_remote_dev (
    .clk_sys_i(clk_sys), .line_o(rx));

  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // One bus cycle; strobes stay low 5 clocks since pins pass a sync pipeline
  task automatic cyc(input logic [3:0] a, input logic wr, input logic [7:0] d);
    @(negedge clk_sys);
    ale = 1'h1;
    cs_n = 1'h0;
    ad = {4'h0, a};
    @(negedge clk_sys);
    ale = 1'h0;
    repeat (3) @(negedge clk_sys);
    ad = d;
    if (wr) wr_n = 1'h0;
    else rd_n = 1'h0;
    repeat (5) @(negedge clk_sys);
    rdat = ad_oe_n ? 8'hEE : ad_o;
    wr_n = 1'h1;
    rd_n = 1'h1;
    cs_n = 1'h1;
    repeat (6) @(negedge clk_sys);
  endtask : cyc

  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string n);
    cyc(a, 1'h0, 8'h00);
    check(n, rdat, exp);
  endtask : rd

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    reset_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    check("tx idle", {7'h00, tx}, 8'h01);
    check("irq", {7'h00, irq}, 8'h00);
    foreach (rows[i]) begin
      if (rows[i].wr) cyc(rows[i].a, 1'h1, rows[i].d);
      else rd(rows[i].a, rows[i].d, "row");
    end
    $display("test registers done");
    cts_n = 1'h1;
    cyc(4'h7, 1'h1, 8'h41);
    rd(4'hF, 8'h10, "held by cts");
    check("tx held", {7'h00, tx}, 8'h01);
    cts_n = 1'h0;
    repeat (5) @(negedge clk_sys);
    rd(4'hF, 8'hA0, "loaded");
    check("start bit", {7'h00, tx}, 8'h00);
    rd(4'h6, 8'h14, "tx vector");
    repeat (11 * 32 * STEPS) @(negedge clk_sys);
    rd(4'hF, 8'hB0, "tx finished");
    ack_n = 1'h0;
    repeat (5) @(negedge clk_sys);
    ack_n = 1'h1;
    repeat (6) @(negedge clk_sys);
    check("irq acked", {7'h00, irq}, 8'h00);
    $display("test transmit done");
    cyc(4'h2, 1'h1, 8'h40);
    u_ussc_remote_dev.send(8'h5A, 1'h0, 1'h0, 1'h1);
    rd(4'hF, 8'hF0, "rx full");
    rd(4'h7, 8'h5A, "rx data");
    rd(4'h6, 8'h10, "rx vector");
    rd(4'hF, 8'h30, "rx cleared");
    cyc(4'h1, 1'h1, 8'hC0);
    u_ussc_remote_dev.send(8'h01, 1'h1, 1'h0, 1'h1);
    rd(4'hF, 8'hF4, "parity set");
    rd(4'hF, 8'hF0, "parity read clear");
    rd(4'h7, 8'h01, "parity data");
    rd(4'h6, 8'h10, "parity vector");
    $display("test receive done");
    cyc(4'h1, 1'h1, 8'h00);
    u_ussc_remote_dev.send(8'h00, 1'h0, 1'h0, 1'h0);
    rd(4'hF, 8'hB8, "break");
    rd(4'h6, 8'h10, "break vector");
    rd(4'hF, 8'h30, "break cleared");
    $display("test break done");
    cyc(4'h0, 1'h1, 8'h08);
    // Echo mode with sample point 17, one step after the default 16; own transmitter runs through the frame
    cyc(4'hF, 1'h1, 8'h7E);
    brk_in_n = 1'h0;
    cyc(4'h7, 1'h1, 8'h55);
    u_ussc_remote_dev.send(8'hC3, 1'h0, 1'h0, 1'h1);
    rd(4'hF, 8'hF9, "echo and break-in");
    rd(4'hF, 8'hF1, "echo framing kept");
    brk_in_n = 1'h1;
    $display("test echo done");
    reset_n = 1'h0;
    repeat (2) @(negedge clk_sys);
    check("reset tx", {7'h00, tx}, 8'h01);
    reset_n = 1'h1;
    repeat (4) @(negedge clk_sys);
    rd(4'hF, 8'h30, "reset status");
    rd(4'h0, 8'h00, "reset cmd1");
    rd(4'h7, 8'hC3, "rx buffer kept");
    $display("test reset done");
    give_verdict();
  end
endmodule : tb_uart_status_and_sample_control
